// File: logic/acrs_pkg.sv
// Package of constants, types and helpers for the converter clock and reference select block
package acrs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ACRS_OFF_REF = 12'h000;
  localparam logic [11:0] ACRS_OFF_DIV = 12'h004;
  localparam logic [11:0] ACRS_OFF_CTL = 12'h008;
  localparam logic [11:0] ACRS_OFF_STS = 12'h00c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACRS_REF_PREF_LSB = 0;
  localparam int ACRS_REF_LVL_LSB = 2;
  localparam int ACRS_REF_NREF_BIT = 4;
  localparam int ACRS_DIV_LSB = 0;
  localparam int ACRS_CTL_GO_BIT = 0;
  localparam int ACRS_CTL_SRC_BIT = 4;
  localparam int ACRS_CTL_EN_BIT = 7;
  localparam int ACRS_STS_BUSY_BIT = 0;
  localparam int ACRS_STS_DONE_BIT = 1;
  localparam int ACRS_STS_CNT_LSB = 8;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ACRS_PREF_SUPPLY = 2'h0;
  localparam logic [1:0] ACRS_PREF_RSVD = 2'h1;
  localparam logic [1:0] ACRS_PREF_PIN = 2'h2;
  localparam logic [1:0] ACRS_PREF_FIXED = 2'h3;
  localparam logic [1:0] ACRS_LVL_1024 = 2'h1;
  localparam logic [1:0] ACRS_LVL_2048 = 2'h2;
  localparam logic [1:0] ACRS_LVL_4096 = 2'h3;
  localparam logic [1:0] ACRS_RST_PREF = 2'h0;
  localparam logic [1:0] ACRS_RST_LVL = 2'h1;
  localparam logic ACRS_RST_NREF = 1'b0;
  localparam logic [5:0] ACRS_RST_DIV = 6'h00;
  localparam logic ACRS_RST_SRC = 1'b0;
  localparam logic ACRS_RST_EN = 1'b0;

  // ----------------------------------------------------------------
  // Timing: 11.5 periods, counted as half periods
  // ----------------------------------------------------------------
  localparam int ACRS_CONV_PER_X10 = 115;
  localparam logic [4:0] ACRS_HALF_TICKS = 5'(ACRS_CONV_PER_X10 * 2 / 10);

  typedef enum logic [2:0] {
    ACRS_ROUTE_PIN = 3'b000,
    ACRS_ROUTE_SUPPLY = 3'b001,
    ACRS_ROUTE_F1024 = 3'b010,
    ACRS_ROUTE_F2048 = 3'b011,
    ACRS_ROUTE_F4096 = 3'b100
  } acrs_route_t;

  typedef enum logic {
    ACRS_IDLE = 1'b0,
    ACRS_CONV = 1'b1
  } acrs_state_t;

  // Reserved select code falls back to the supply rail
  function automatic acrs_route_t acrs_route(input logic [1:0] pref, input logic [1:0] lvl);
    acrs_route_t r;
    r = ACRS_ROUTE_SUPPLY;
    if (pref == ACRS_PREF_PIN) begin
      r = ACRS_ROUTE_PIN;
    end else if (pref == ACRS_PREF_FIXED) begin
      if (lvl == ACRS_LVL_4096) begin
        r = ACRS_ROUTE_F4096;
      end else if (lvl == ACRS_LVL_2048) begin
        r = ACRS_ROUTE_F2048;
      end else begin
        r = ACRS_ROUTE_F1024;
      end
    end
    return r;
  endfunction

  function automatic logic acrs_mapped(input logic [11:0] addr);
    return (addr == ACRS_OFF_REF) || (addr == ACRS_OFF_DIV) || (addr == ACRS_OFF_CTL) || (addr == ACRS_OFF_STS);
  endfunction

endpackage

// File: logic/acrs_clkdiv.sv
// Conversion clock generator: programmable divider or RC oscillator edges
`timescale 1ns/10ps
`default_nettype none
module acrs_clkdiv
  import acrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [5:0] div_sel,
  input wire logic src_rc,
  input wire logic rc_osc,
  output logic half_tick,
  output logic conv_clk
);

  logic [5:0] cnt_q, cnt_d;
  logic rc_prev_q, rc_prev_d;
  logic tick_d, clk_d;

  // ----------------------------------------------------------------
  // Half-period generation
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    rc_prev_d = rc_osc;
    tick_d = 1'b0;
    if (src_rc) begin
      cnt_d = 6'h00;
      tick_d = rc_osc ^ rc_prev_q;
    end else if (cnt_q >= div_sel) begin
      // Compare with >= so a smaller divider never strands the count
      cnt_d = 6'h00;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 6'h01;
    end
    clk_d = conv_clk ^ tick_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      rc_prev_q <= 1'b0;
      half_tick <= 1'b0;
      conv_clk <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      rc_prev_q <= rc_prev_d;
      half_tick <= tick_d;
      conv_clk <= clk_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_div_tick: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !src_rc && cnt_q >= div_sel |=> half_tick && cnt_q == 6'h00)
    else $error("divider did not tick at its terminal count");

  a_div_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !src_rc && cnt_q < div_sel |=> !half_tick)
    else $error("divider ticked early");

  a_rc_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ce && src_rc && (rc_osc != rc_prev_q) |=> half_tick && $changed(conv_clk))
    else $error("RC edge did not produce a half period");

  a_clk_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> ($changed(conv_clk) == half_tick))
    else $error("conversion clock toggled without a half tick");

endmodule
`default_nettype wire

// File: logic/acrs_top.sv
// Converter clock and reference select: APB registers, clock choice and conversion timing
`timescale 1ns/10ps
`default_nettype none
module acrs_top
  import acrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_osc,
  output logic [2:0] pos_ref_route,
  output logic neg_ref_pin,
  output logic conv_clk,
  output logic conv_busy,
  output logic conv_done
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic setup, wr, half_tick, take;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  // Software copies
  logic [1:0] pref_q, pref_d, lvl_q, lvl_d;
  logic nref_q, nref_d, src_q, src_d, en_q, en_d, go_q, go_d, done_flag_q, done_flag_d;
  logic [5:0] div_q, div_d;
  // Active copies, as seen by the conversion clock
  logic [1:0] act_pref_q, act_pref_d, act_lvl_q, act_lvl_d;
  logic act_nref_q, act_nref_d, act_src_q, act_src_d;
  logic [5:0] act_div_q, act_div_d;
  // Conversion sequencing
  acrs_state_t state_q, state_d;
  logic [4:0] half_cnt_q, half_cnt_d;
  logic [2:0] route_d;
  logic busy_d, done_d;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states: pready rises in the access cycle that follows each setup
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;

  always_comb begin
    prdata_d = prdata;
    pready_d = setup;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = ~acrs_mapped(paddr);
      unique case (paddr)
        ACRS_OFF_REF: begin
          prdata_d[ACRS_REF_PREF_LSB +: 2] = pref_q;
          prdata_d[ACRS_REF_LVL_LSB +: 2] = lvl_q;
          prdata_d[ACRS_REF_NREF_BIT] = nref_q;
        end
        ACRS_OFF_DIV: begin
          prdata_d[ACRS_DIV_LSB +: 6] = div_q;
        end
        ACRS_OFF_CTL: begin
          prdata_d[ACRS_CTL_GO_BIT] = go_q;
          prdata_d[ACRS_CTL_SRC_BIT] = src_q;
          prdata_d[ACRS_CTL_EN_BIT] = en_q;
        end
        ACRS_OFF_STS: begin
          prdata_d[ACRS_STS_BUSY_BIT] = conv_busy;
          prdata_d[ACRS_STS_DONE_BIT] = done_flag_q;
          prdata_d[ACRS_STS_CNT_LSB +: 5] = half_cnt_q;
        end
        default: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Software-visible control
  // ----------------------------------------------------------------
  always_comb begin
    pref_d = pref_q;
    lvl_d = lvl_q;
    nref_d = nref_q;
    div_d = div_q;
    src_d = src_q;
    en_d = en_q;
    go_d = go_q & ~take;
    done_flag_d = done_flag_q;
    if (wr && paddr == ACRS_OFF_REF) begin
      pref_d = pwdata[ACRS_REF_PREF_LSB +: 2];
      lvl_d = pwdata[ACRS_REF_LVL_LSB +: 2];
      nref_d = pwdata[ACRS_REF_NREF_BIT];
    end
    if (wr && paddr == ACRS_OFF_DIV) begin
      div_d = pwdata[ACRS_DIV_LSB +: 6];
    end
    if (wr && paddr == ACRS_OFF_CTL) begin
      src_d = pwdata[ACRS_CTL_SRC_BIT];
      en_d = pwdata[ACRS_CTL_EN_BIT];
      go_d = go_d | pwdata[ACRS_CTL_GO_BIT];
    end
    if (wr && paddr == ACRS_OFF_STS && pwdata[ACRS_STS_DONE_BIT]) begin
      done_flag_d = 1'b0;
    end
    // A completion in the clearing cycle wins over the clear
    if (done_d) begin
      done_flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_q <= ACRS_RST_PREF;
      lvl_q <= ACRS_RST_LVL;
      nref_q <= ACRS_RST_NREF;
      div_q <= ACRS_RST_DIV;
      src_q <= ACRS_RST_SRC;
      en_q <= ACRS_RST_EN;
      go_q <= 1'b0;
      done_flag_q <= 1'b0;
    end else if (ce) begin
      pref_q <= pref_d;
      lvl_q <= lvl_d;
      nref_q <= nref_d;
      div_q <= div_d;
      src_q <= src_d;
      en_q <= en_d;
      go_q <= go_d;
      done_flag_q <= done_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Transfer into the conversion clock
  // ----------------------------------------------------------------
  // Settings move only on a conversion clock edge and only between
  // conversions, so a running conversion keeps its timing and references.
  // On the RC source this adds up to a full RC half period of delay, and
  // a stopped RC oscillator holds the old settings until it runs again.
  always_comb begin
    act_pref_d = act_pref_q;
    act_lvl_d = act_lvl_q;
    act_nref_d = act_nref_q;
    act_div_d = act_div_q;
    act_src_d = act_src_q;
    if (half_tick && state_q == ACRS_IDLE) begin
      act_pref_d = pref_q;
      act_lvl_d = lvl_q;
      act_nref_d = nref_q;
      act_div_d = div_q;
      act_src_d = src_q;
    end
    route_d = acrs_route(act_pref_q, act_lvl_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_pref_q <= ACRS_RST_PREF;
      act_lvl_q <= ACRS_RST_LVL;
      act_nref_q <= ACRS_RST_NREF;
      act_div_q <= ACRS_RST_DIV;
      act_src_q <= ACRS_RST_SRC;
      pos_ref_route <= ACRS_ROUTE_SUPPLY;
      neg_ref_pin <= ACRS_RST_NREF;
    end else if (ce) begin
      act_pref_q <= act_pref_d;
      act_lvl_q <= act_lvl_d;
      act_nref_q <= act_nref_d;
      act_div_q <= act_div_d;
      act_src_q <= act_src_d;
      pos_ref_route <= route_d;
      neg_ref_pin <= act_nref_q;
    end
  end

  acrs_clkdiv u_clkdiv (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .div_sel(act_div_q),
    .src_rc(act_src_q),
    .rc_osc(rc_osc),
    .half_tick(half_tick),
    .conv_clk(conv_clk)
  );

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // Divider and period limits are not checked here; software must keep
  // the period inside the converter's timing window.
  assign take = (state_q == ACRS_IDLE) && half_tick && go_q && en_q;

  always_comb begin
    state_d = state_q;
    half_cnt_d = half_cnt_q;
    done_d = 1'b0;
    unique case (state_q)
      ACRS_IDLE: begin
        if (take) begin
          state_d = ACRS_CONV;
          half_cnt_d = 5'h00;
        end
      end
      ACRS_CONV: begin
        if (!en_q) begin
          // Disabling aborts without a completion
          state_d = ACRS_IDLE;
        end else if (half_tick) begin
          if (half_cnt_q == ACRS_HALF_TICKS - 5'h01) begin
            state_d = ACRS_IDLE;
            done_d = 1'b1;
          end
          half_cnt_d = half_cnt_q + 5'h01;
        end
      end
    endcase
    busy_d = (state_d == ACRS_CONV);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ACRS_IDLE;
      half_cnt_q <= 5'h00;
      conv_busy <= 1'b0;
      conv_done <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      half_cnt_q <= half_cnt_d;
      conv_busy <= busy_d;
      conv_done <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_apb_setup;
    psel && !penable && ce;
  endsequence

  sequence s_apb_access;
    psel && penable && ce;
  endsequence

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup ##1 s_apb_access |-> pready ##1 !pready)
    else $error("APB ready not a single access cycle");

  a_apb_slverr: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && ce && !acrs_mapped(paddr) |=> pslverr && pready)
    else $error("unmapped address not flagged");

  a_pref_fixed4: assert property (@(posedge pclk) disable iff (!presetn)
    ce && act_pref_q == ACRS_PREF_FIXED && act_lvl_q == ACRS_LVL_4096 |=> pos_ref_route == ACRS_ROUTE_F4096)
    else $error("fixed 4.096 reference not routed");

  a_pref_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ce && act_pref_q == ACRS_PREF_PIN |=> pos_ref_route == ACRS_ROUTE_PIN)
    else $error("reference pin not routed");

  a_nref_route: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> neg_ref_pin == $past(act_nref_q))
    else $error("negative reference select not followed");

  a_cfg_at_tick: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(act_div_q) || $changed(act_src_q) |-> $past(half_tick) && ($past(state_q) == ACRS_IDLE))
    else $error("clock setting changed off a conversion clock edge");

  a_start_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conv_busy) |-> $past(half_tick) && $past(go_q) && $past(en_q))
    else $error("conversion started without a pending start and clock edge");

  a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_q == ACRS_CONV && en_q && half_tick && half_cnt_q == ACRS_HALF_TICKS - 5'h01
      |=> conv_done && !conv_busy && done_flag_q)
    else $error("conversion did not end after 23 half periods");

  a_done_only_end: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conv_done) |-> $past(half_cnt_q) == ACRS_HALF_TICKS - 5'h01)
    else $error("completion before full conversion length");

  a_go_held: assert property (@(posedge pclk) disable iff (!presetn)
    ce && go_q && !take |=> go_q)
    else $error("pending start lost before being taken");

endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the converter clock and reference select block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import acrs_pkg::*;
;
  localparam int LIMIT = 40000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rc_osc = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, neg_ref_pin, conv_clk, conv_busy, conv_done;
  logic [2:0] pos_ref_route;
  int failures = 0;
  int cmp_count = 0;
  int rc_half = 0;
  int rc_cnt = 0;

  acrs_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_osc(rc_osc),
    .pos_ref_route(pos_ref_route), .neg_ref_pin(neg_ref_pin), .conv_clk(conv_clk), .conv_busy(conv_busy),
    .conv_done(conv_done));

  always #12.5 pclk = ~pclk;

  // RC oscillator stand-in, synchronous to pclk as the design expects
  always @(posedge pclk) begin
    if (rc_half > 0) begin
      if (rc_cnt >= rc_half - 1) begin
        rc_cnt <= 0;
        rc_osc <= ~rc_osc;
      end else begin
        rc_cnt <= rc_cnt + 1;
      end
    end
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until pready is sampled high, then releases after that edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; a lost answer is ended by the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
    chk({31'h0, e}, {31'h0, err}, "write error flag");
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 32'h0, r, e);
    chk(r & mask, exp, "read data");
    chk({31'h0, e}, {31'h0, err}, "read error flag");
  endtask

  function automatic logic [2:0] m_route(int pref, int lvl);
    if (pref == 2) return 3'h0;
    if (pref != 3) return 3'h1;
    if (lvl == 3) return 3'h4;
    if (lvl == 2) return 3'h3;
    return 3'h2;
  endfunction

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < 5000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic meas_clk(input int exp_half);
    int n;
    logic prev;
    for (int k = 0; k < 2; k++) begin
      prev = conv_clk;
      n = 0;
      while (conv_clk === prev && n < 500) begin
        @(posedge pclk);
        n++;
      end
    end
    chk(n, exp_half, "conversion clock half period");
  endtask

  // One conversion lasts 23 half periods of the chosen clock
  task automatic run_conv(input int h, input logic [31:0] src);
    int n;
    wr(ACRS_OFF_CTL, 32'h81 | src, 1'b0);
    wait_busy(1'b1);
    n = 0;
    while (conv_busy === 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 23 * h, "busy length");
    chk({31'h0, conv_done}, 32'h1, "done pulse");
    @(posedge pclk);
    chk({31'h0, conv_done}, 32'h0, "done width");
    rdc(ACRS_OFF_STS, 32'h1f03, 32'h1702, 1'b0);
    wr(ACRS_OFF_STS, 32'h2, 1'b0);
    rdc(ACRS_OFF_STS, 32'h3, 32'h0, 1'b0);
    rdc(ACRS_OFF_CTL, 32'hff, 32'h80 | src, 1'b0);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (LIMIT) @(posedge pclk);
    failures++;
    $display("Error at %0t: timeout", $time);
    stop_test();
  end

  initial begin
    int nr, n, d;
    int divs[4];
    void'($urandom(14796));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, pos_ref_route}, 32'h1, "reset route");
    chk({29'h0, neg_ref_pin, conv_busy, conv_done}, 32'h0, "reset outputs");
    rdc(ACRS_OFF_REF, 32'hffffffff, 32'h4, 1'b0);
    rdc(ACRS_OFF_DIV, 32'hffffffff, 32'h0, 1'b0);
    rdc(ACRS_OFF_CTL, 32'hffffffff, 32'h0, 1'b0);
    rdc(12'h010, 32'hffffffff, 32'h0, 1'b1);
    wr(12'hffc, 32'hffffffff, 1'b1);
    $display("Test reset and map done");

    for (int p = 0; p < 4; p++) begin
      for (int l = 0; l < 4; l++) begin
        nr = $urandom % 2;
        wr(ACRS_OFF_REF, 32'(nr * 16 + l * 4 + p), 1'b0);
        repeat (8) @(posedge pclk);
        chk({29'h0, pos_ref_route}, {29'h0, m_route(p, l)}, "positive route");
        chk({31'h0, neg_ref_pin}, 32'(nr), "negative route");
        rdc(ACRS_OFF_REF, 32'hffffffff, 32'(nr * 16 + l * 4 + p), 1'b0);
      end
    end
    $display("Test references done");

    divs = '{0, 1, 63, 2 + $urandom % 20};
    foreach (divs[i]) begin
      wr(ACRS_OFF_DIV, 32'(divs[i]), 1'b0);
      rdc(ACRS_OFF_DIV, 32'hffffffff, 32'(divs[i]), 1'b0);
      repeat (2 * divs[i] + 6) @(posedge pclk);
      meas_clk(divs[i] + 1);
      run_conv(divs[i] + 1, 32'h0);
    end
    $display("Test divider and conversion done");

    rc_half = 2 + $urandom % 4;
    wr(ACRS_OFF_CTL, 32'h10, 1'b0);
    // The switch waits for a tick of the old divider, so wait that out too
    repeat (4 * rc_half + 2 * divs[3] + 6) @(posedge pclk);
    meas_clk(rc_half);
    run_conv(rc_half, 32'h10);
    wr(ACRS_OFF_REF, 32'h1e, 1'b0);
    repeat (4 * rc_half + 6) @(posedge pclk);
    chk({28'h0, pos_ref_route, neg_ref_pin}, 32'h1, "route under rc clock");
    wr(ACRS_OFF_CTL, 32'h0, 1'b0);
    wr(ACRS_OFF_DIV, 32'h0, 1'b0);
    repeat (4 * rc_half + 6) @(posedge pclk);
    $display("Test rc source done");

    // Start without enable must wait, clearing enable must abort without done
    wr(ACRS_OFF_CTL, 32'h1, 1'b0);
    repeat (20) @(posedge pclk);
    chk({31'h0, conv_busy}, 32'h0, "start while disabled");
    rdc(ACRS_OFF_CTL, 32'hff, 32'h1, 1'b0);
    wr(ACRS_OFF_CTL, 32'h81, 1'b0);
    wait_busy(1'b1);
    repeat (5) @(posedge pclk);
    wr(ACRS_OFF_CTL, 32'h0, 1'b0);
    d = 0;
    repeat (10) begin
      @(posedge pclk);
      if (conv_done === 1'b1) d = 1;
    end
    chk({31'h0, conv_busy}, 32'h0, "abort busy");
    chk(d, 0, "abort done");
    rdc(ACRS_OFF_STS, 32'h3, 32'h0, 1'b0);
    $display("Test pending and abort done");

    // A frozen enable stretches a conversion by exactly the frozen cycles
    wr(ACRS_OFF_CTL, 32'h81, 1'b0);
    wait_busy(1'b1);
    n = 1 + $urandom % 8;
    ce <= 1'b0;
    repeat (n) @(posedge pclk);
    chk({31'h0, conv_busy}, 32'h1, "busy while frozen");
    ce <= 1'b1;
    for (d = n; conv_busy === 1'b1 && d < 5000; d++) @(posedge pclk);
    chk(d, 23 + n, "frozen conversion length");
    $display("Test clock enable done");
    stop_test();
  end
endmodule
`default_nettype wire
